// file: oss_ctrl.sv
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "oss_cfg.svh"

// Overview of operation
// - other sectors read undefined in identification overlay; host exits and re-enters
// - host enters identification overlay writing 0x0098 at 0x55, leaves with 0x00F0 at 0
// - after the status read command the host reads status before any other command
// - secure region entered from read mode; its reads use the entry sector address
module oss_ctrl
	import oss_pkg::*;
#(
	parameter int ADDR_W = 24,
	parameter int SECT_W = 8,
	parameter int DATA_W = 16
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [7:0]        paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [ADDR_W-1:0] flash_addr,
	input  wire logic [DATA_W-1:0] flash_dq_in,
	output logic      [DATA_W-1:0] flash_dq_out,
	output logic                   flash_dq_oe,
	output logic                   flash_ce_n,
	output logic                   flash_we_n,
	output logic                   flash_oe_n
);

	localparam int OFS_W = ADDR_W - SECT_W;

	typedef struct packed {
		oss_ctl_st_t       state;
		oss_op_t           op;
		logic [2:0]        kind;
		logic              legacy;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		oss_ovl_t          ovl;
		logic [SECT_W-1:0] sector;
		logic              err;
		logic              cyc_req;
		logic              cyc_rd;
		logic [ADDR_W-1:0] cyc_addr;
		logic [DATA_W-1:0] cyc_wdata;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} oss_ctl_t;

	oss_ctl_t          q;
	oss_ctl_t          next_q;
	logic              cyc_done;
	logic [DATA_W-1:0] cyc_rdata;
	logic              apb_wr;

	function automatic logic [SECT_W-1:0] oss_sect(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1 -: SECT_W];
	endfunction

	// reads that the overlay leaves undefined are refused before they reach the pins
	function automatic logic oss_read_ok(input oss_ovl_t ov, input logic [ADDR_W-1:0] a,
	                                     input logic [SECT_W-1:0] s);
		logic r;
		r = 1'b1;
		case (ov)
			OSS_OV_IDQ, OSS_OV_SECURE: r = (oss_sect(a) == s);
			OSS_OV_LOCKREG:            r = (a == '0);
			OSS_OV_PASSWORD:           r = (a < ADDR_W'(`OSS_PASSWORD_WORDS));
			default:                   r = 1'b1;
		endcase
		return r;
	endfunction

	assign apb_wr = psel && penable && q.pready && pwrite;

	// ----------------------------------------------------------------
	// register access and command sequencing
	// ----------------------------------------------------------------
	always_comb begin
		next_q         = q;
		next_q.cyc_req = 1'b0;
		next_q.pready  = 1'b0;
		next_q.pslverr = 1'b0;
		// one wait state keeps prdata and pready on flip-flops
		if (psel && penable && !q.pready) begin
			next_q.pready = 1'b1;
			next_q.prdata = '0;
			case (paddr)
				`OSS_REG_CTRL:   next_q.prdata = {23'h0, q.legacy, 1'b0, q.kind, 1'b0, q.op};
				`OSS_REG_ADDR:   next_q.prdata = 32'(q.addr);
				`OSS_REG_WDATA:  next_q.prdata = 32'(q.wdata);
				`OSS_REG_RDATA:  next_q.prdata = 32'(q.rdata);
				`OSS_REG_STATUS: next_q.prdata = {16'h0, q.ovl, 6'h0, q.err,
				                                  q.state != OSS_C_IDLE};
				`OSS_REG_SECTOR: next_q.prdata = 32'(q.sector);
				default:         next_q.pslverr = 1'b1;
			endcase
		end
		if (apb_wr) begin
			case (paddr)
				`OSS_REG_ADDR:   next_q.addr = pwdata[ADDR_W-1:0];
				`OSS_REG_WDATA:  next_q.wdata = pwdata[DATA_W-1:0];
				`OSS_REG_STATUS: if (pwdata[`OSS_STAT_ERR_BIT]) next_q.err = 1'b0;
				default:         ;
			endcase
		end
		unique case (q.state)
			OSS_C_IDLE: begin
				if (apb_wr && paddr == `OSS_REG_CTRL) begin
					next_q.op        = oss_op_t'(pwdata[`OSS_CTRL_OP_LSB +: 3]);
					next_q.kind      = pwdata[`OSS_CTRL_KIND_LSB +: 3];
					next_q.legacy    = pwdata[`OSS_CTRL_LEGACY_BIT];
					next_q.cyc_rd    = 1'b0;
					next_q.cyc_addr  = q.addr;
					next_q.cyc_wdata = q.wdata;
					next_q.cyc_req   = 1'b1;
					next_q.state     = OSS_C_WR;
					case (next_q.op)
						OSS_OP_READ: begin
							next_q.cyc_rd = 1'b1;
							next_q.state  = OSS_C_RD;
							if (!oss_read_ok(q.ovl, q.addr, q.sector)) begin
								next_q.cyc_req = 1'b0;
								next_q.state   = OSS_C_IDLE;
								next_q.err     = 1'b1;
							end
						end
						// raw word writes carry every overlay's program and unlock cycles
						OSS_OP_WRITE, OSS_OP_STATUS: ;
						OSS_OP_ENTER: begin
							// entries only from read mode; otherwise nothing is sent
							if (q.ovl != OSS_OV_READ ||
							    oss_kind_to_ovl(next_q.kind) == OSS_OV_READ) begin
								next_q.cyc_req = 1'b0;
								next_q.state   = OSS_C_IDLE;
								next_q.err     = 1'b1;
							end else if (next_q.kind == `OSS_KIND_IDQ) begin
								next_q.cyc_addr  = {oss_sect(q.addr),
								                    OFS_W'(`OSS_ID_ENTRY_OFS)};
								next_q.cyc_wdata = DATA_W'(`OSS_ID_ENTRY_CMD);
							end
						end
						OSS_OP_EXIT: begin
							// legacy exit sends the software-supplied code instead
							next_q.cyc_addr = ADDR_W'(`OSS_EXIT_OFS);
							if (!next_q.legacy) begin
								next_q.cyc_wdata = DATA_W'(`OSS_EXIT_CMD);
							end
						end
						default: begin
							next_q.cyc_req = 1'b0;
							next_q.state   = OSS_C_IDLE;
							next_q.err     = 1'b1;
						end
					endcase
				end
			end
			OSS_C_WR: begin
				// no command, reset included, is sent while a cycle is running
				if (apb_wr && paddr == `OSS_REG_CTRL) begin
					next_q.err = 1'b1;
				end
				if (cyc_done) begin
					next_q.state = OSS_C_IDLE;
					if (q.op == OSS_OP_STATUS) begin
						// status must be read before anything else is sent
						next_q.cyc_req = 1'b1;
						next_q.cyc_rd  = 1'b1;
						next_q.state   = OSS_C_RD;
					end else if (q.op == OSS_OP_ENTER) begin
						next_q.ovl    = oss_kind_to_ovl(q.kind);
						next_q.sector = oss_sect(q.cyc_addr);
					end else if (q.op == OSS_OP_EXIT) begin
						next_q.ovl = OSS_OV_READ;
					end
				end
			end
			OSS_C_RD: begin
				if (apb_wr && paddr == `OSS_REG_CTRL) begin
					next_q.err = 1'b1;
				end
				// the overlay map is untouched: the one-shot status overlay ends itself
				if (cyc_done) begin
					next_q.rdata = cyc_rdata;
					next_q.state = OSS_C_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{state: OSS_C_IDLE, op: OSS_OP_READ, ovl: OSS_OV_READ, default: '0};
		end else begin
			q <= next_q;
		end
	end

	assign prdata  = q.prdata;
	assign pready  = q.pready;
	assign pslverr = q.pslverr;

	// ----------------------------------------------------------------
	// flash pin engine
	// ----------------------------------------------------------------
	oss_flash_cycle #(
		.ADDR_W (ADDR_W),
		.DATA_W (DATA_W)
	) u_cycle (
		.pclk         (pclk),
		.presetn      (presetn),
		.req          (q.cyc_req),
		.req_rd       (q.cyc_rd),
		.req_addr     (q.cyc_addr),
		.req_wdata    (q.cyc_wdata),
		.done         (cyc_done),
		.rdata        (cyc_rdata),
		.flash_addr   (flash_addr),
		.flash_dq_in  (flash_dq_in),
		.flash_dq_out (flash_dq_out),
		.flash_dq_oe  (flash_dq_oe),
		.flash_ce_n   (flash_ce_n),
		.flash_we_n   (flash_we_n),
		.flash_oe_n   (flash_oe_n)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_status_wr_done;
		q.state == OSS_C_WR && q.op == OSS_OP_STATUS && cyc_done;
	endsequence
	sequence s_status_rd_issued;
		q.cyc_req && q.cyc_rd && q.state == OSS_C_RD;
	endsequence

	a_status_read_next: assert property (s_status_wr_done |=> s_status_rd_issued)
		else $error("status read did not follow status command");
	a_status_no_ovl: assert property (s_status_wr_done |=> $stable(q.ovl) [*2])
		else $error("status command changed overlay");
	a_id_entry_code: assert property ((q.cyc_req && q.op == OSS_OP_ENTER &&
		q.kind == `OSS_KIND_IDQ) |-> (q.cyc_wdata == DATA_W'(`OSS_ID_ENTRY_CMD) &&
		q.cyc_addr[OFS_W-1:0] == OFS_W'(`OSS_ID_ENTRY_OFS) &&
		oss_sect(q.cyc_addr) == oss_sect(q.addr)))
		else $error("identification entry pattern wrong");
	a_exit_code: assert property ((q.cyc_req && q.op == OSS_OP_EXIT && !q.legacy) |->
		(q.cyc_wdata == DATA_W'(`OSS_EXIT_CMD) && q.cyc_addr == '0))
		else $error("exit pattern wrong");
	a_exit_to_read: assert property ((q.state == OSS_C_WR && q.op == OSS_OP_EXIT && cyc_done)
		|=> q.ovl == OSS_OV_READ && q.state == OSS_C_IDLE)
		else $error("exit did not restore read mode");
	a_entry_sector: assert property ((q.state == OSS_C_WR && q.op == OSS_OP_ENTER && cyc_done)
		|=> q.ovl == oss_kind_to_ovl($past(q.kind)) &&
		q.sector == oss_sect($past(q.cyc_addr)))
		else $error("entry did not record overlay and sector");
	a_entry_from_read: assert property (($changed(q.ovl) && q.ovl != OSS_OV_READ) |->
		$past(q.ovl) == OSS_OV_READ)
		else $error("overlay entered outside read mode");
	a_sector_refused: assert property ((q.state == OSS_C_IDLE && apb_wr &&
		paddr == `OSS_REG_CTRL && pwdata[2:0] == OSS_OP_READ &&
		(q.ovl == OSS_OV_IDQ || q.ovl == OSS_OV_SECURE) && oss_sect(q.addr) != q.sector)
		|=> q.err && !q.cyc_req && q.state == OSS_C_IDLE)
		else $error("read at foreign sector was sent");
	a_apb_one_wait: assert property ((psel && penable && !q.pready) |=> q.pready ##1 !q.pready)
		else $error("apb answer timing wrong");

endmodule
`default_nettype wire

// file: oss_cfg.svh
`ifndef OSS_CFG_SVH
`define OSS_CFG_SVH

// ----------------------------------------------------------------
// clock and flash strobe timing
// ----------------------------------------------------------------
`define OSS_CLK_NS          10
`define OSS_T_WP_NS         30
`define OSS_T_WPH_NS        30
`define OSS_T_ACC_NS        80
`define OSS_SYNC_STAGES     2
// least time in whole cycles, never below one
`define OSS_CYC(ns)         ((((ns) + `OSS_CLK_NS - 1) / `OSS_CLK_NS) < 1 ? 1 : \
                             (((ns) + `OSS_CLK_NS - 1) / `OSS_CLK_NS))

// ----------------------------------------------------------------
// register offsets (byte addresses on the apb side)
// ----------------------------------------------------------------
`define OSS_REG_CTRL        8'h00
`define OSS_REG_ADDR        8'h04
`define OSS_REG_WDATA       8'h08
`define OSS_REG_RDATA       8'h0c
`define OSS_REG_STATUS      8'h10
`define OSS_REG_SECTOR      8'h14

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define OSS_CTRL_OP_LSB     0
`define OSS_CTRL_KIND_LSB   4
`define OSS_CTRL_LEGACY_BIT 8
`define OSS_STAT_ERR_BIT    1
`define OSS_KIND_IDQ        3'h1
`define OSS_PASSWORD_WORDS  4
`define OSS_ID_ENTRY_OFS    16'h0055
`define OSS_ID_ENTRY_CMD    16'h0098
`define OSS_EXIT_OFS        16'h0000
`define OSS_EXIT_CMD        16'h00f0

`endif

// file: oss_pkg.sv
package oss_pkg;

	// controller sequencing states
	typedef enum logic [2:0] {
		OSS_C_IDLE = 3'b001,
		OSS_C_WR   = 3'b010,
		OSS_C_RD   = 3'b100
	} oss_ctl_st_t;

	// flash pin cycle states
	typedef enum logic [3:0] {
		OSS_B_IDLE = 4'b0001,
		OSS_B_WLO  = 4'b0010,
		OSS_B_WHI  = 4'b0100,
		OSS_B_RLO  = 4'b1000
	} oss_bus_st_t;

	// overlay the device currently shows; bit index is the kind code
	typedef enum logic [7:0] {
		OSS_OV_READ     = 8'h01,
		OSS_OV_IDQ      = 8'h02,
		OSS_OV_SECURE   = 8'h04,
		OSS_OV_LOCKREG  = 8'h08,
		OSS_OV_PASSWORD = 8'h10,
		OSS_OV_PPB      = 8'h20,
		OSS_OV_PPBLOCK  = 8'h40,
		OSS_OV_DYB      = 8'h80
	} oss_ovl_t;

	typedef enum logic [2:0] {
		OSS_OP_READ   = 3'h0,
		OSS_OP_WRITE  = 3'h1,
		OSS_OP_ENTER  = 3'h2,
		OSS_OP_EXIT   = 3'h3,
		OSS_OP_STATUS = 3'h4
	} oss_op_t;

	function automatic oss_ovl_t oss_kind_to_ovl(input logic [2:0] kind);
		return oss_ovl_t'(8'h01 << kind);
	endfunction

endpackage

// file: oss_flash_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "oss_cfg.svh"

module oss_flash_cycle
	import oss_pkg::*;
#(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              req,
	input  wire logic              req_rd,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   done,
	output logic      [DATA_W-1:0] rdata,
	output logic      [ADDR_W-1:0] flash_addr,
	input  wire logic [DATA_W-1:0] flash_dq_in,
	output logic      [DATA_W-1:0] flash_dq_out,
	output logic                   flash_dq_oe,
	output logic                   flash_ce_n,
	output logic                   flash_we_n,
	output logic                   flash_oe_n
);

	localparam int WP_C  = `OSS_CYC(`OSS_T_WP_NS);
	localparam int WPH_C = `OSS_CYC(`OSS_T_WPH_NS);
	// sampled data lags the pins by the synchroniser plus one capture edge
	localparam int RD_C  = `OSS_CYC(`OSS_T_ACC_NS) + `OSS_SYNC_STAGES + 1;

	typedef struct packed {
		oss_bus_st_t       state;
		logic [7:0]        cnt;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic              dq_oe;
		logic              ce_n;
		logic              we_n;
		logic              oe_n;
		logic              done;
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] sync1;
		logic [DATA_W-1:0] sync2;
	} oss_cyc_t;

	oss_cyc_t q;
	oss_cyc_t next_q;

	// ----------------------------------------------------------------
	// pin sequencing
	// ----------------------------------------------------------------
	always_comb begin
		next_q       = q;
		next_q.done  = 1'b0;
		next_q.sync1 = flash_dq_in;
		next_q.sync2 = q.sync1;
		unique case (q.state)
			OSS_B_IDLE: begin
				if (req) begin
					next_q.addr = req_addr;
					next_q.ce_n = 1'b0;
					if (req_rd) begin
						next_q.oe_n  = 1'b0;
						next_q.cnt   = 8'(RD_C - 1);
						next_q.state = OSS_B_RLO;
					end else begin
						next_q.dout  = req_wdata;
						next_q.dq_oe = 1'b1;
						next_q.we_n  = 1'b0;
						next_q.cnt   = 8'(WP_C - 1);
						next_q.state = OSS_B_WLO;
					end
				end
			end
			OSS_B_WLO: begin
				if (q.cnt == 8'h00) begin
					next_q.we_n  = 1'b1;
					next_q.cnt   = 8'(WPH_C - 1);
					next_q.state = OSS_B_WHI;
				end else begin
					next_q.cnt = q.cnt - 8'h01;
				end
			end
			OSS_B_WHI: begin
				// a reset command is complete once this high time has passed
				if (q.cnt == 8'h00) begin
					next_q.ce_n  = 1'b1;
					next_q.dq_oe = 1'b0;
					next_q.done  = 1'b1;
					next_q.state = OSS_B_IDLE;
				end else begin
					next_q.cnt = q.cnt - 8'h01;
				end
			end
			OSS_B_RLO: begin
				// oe and ce rise after the read so a one-shot overlay is left
				if (q.cnt == 8'h00) begin
					next_q.rdata = q.sync2;
					next_q.oe_n  = 1'b1;
					next_q.ce_n  = 1'b1;
					next_q.done  = 1'b1;
					next_q.state = OSS_B_IDLE;
				end else begin
					next_q.cnt = q.cnt - 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{state: OSS_B_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
		end else begin
			q <= next_q;
		end
	end

	assign done         = q.done;
	assign rdata        = q.rdata;
	assign flash_addr   = q.addr;
	assign flash_dq_out = q.dout;
	assign flash_dq_oe  = q.dq_oe;
	assign flash_ce_n   = q.ce_n;
	assign flash_we_n   = q.we_n;
	assign flash_oe_n   = q.oe_n;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_we_low_width: assert property ($fell(q.we_n) |-> ##WP_C $rose(q.we_n))
		else $error("write strobe low time wrong");
	// done comes on the edge after the last high-time count, strobe still high
	a_we_high_done: assert property ($rose(q.we_n) |-> ##WPH_C (q.we_n && q.done))
		else $error("write strobe high time wrong");
	a_write_drive: assert property (!q.we_n |-> q.dq_oe && !q.ce_n && q.oe_n)
		else $error("write strobe without data drive");
	a_read_window: assert property ($fell(q.oe_n) |-> ##RD_C ($rose(q.oe_n) && q.done))
		else $error("read strobe length wrong");
	a_no_contention: assert property (!q.oe_n |-> !q.dq_oe)
		else $error("data driven during read");
	a_addr_stable: assert property ((!q.ce_n && !$past(q.ce_n)) |-> $stable(q.addr))
		else $error("address moved during cycle");

endmodule
`default_nettype wire

// file: oss_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// behavioural flash device seen through its strobes
// ----------------------------------------------------------------
// command codes other than identification entry and exit are free values
module oss_flash_model
	import oss_pkg::*;
#(
	parameter logic [15:0] ENT_DYB  = 16'h00e0,
	parameter logic [15:0] STAT_CMD = 16'h0070,
	parameter logic [15:0] PGM_CMD  = 16'h00a0,
	parameter logic [15:0] STAT_VAL = 16'h0080
) (
	input  wire logic [23:0] flash_addr,
	output logic      [15:0] flash_dq_in,
	input  wire logic [15:0] flash_dq_out,
	input  wire logic        flash_dq_oe,
	input  wire logic        flash_ce_n,
	input  wire logic        flash_we_n,
	input  wire logic        flash_oe_n
);
	oss_ovl_t     ovl     = OSS_OV_READ;
	logic [7:0]   sect    = 8'h00;
	logic         st_pend = 1'b0;
	logic         armed   = 1'b0;
	logic [255:0] persistent_protect_bit     = '1;
	logic [255:0] dynamic_protect_bit     = ~256'h2;
	logic [15:0]  val;
	logic [15:0]  last    = 16'h0000;

	// read data: array pattern unless an overlay covers it
	always_comb begin
		val = flash_addr[15:0] ^ 16'h5a5a;
		if (st_pend)
			val = STAT_VAL;
		else if (ovl == OSS_OV_IDQ && flash_addr[23:16] != sect)
			val = ~val;
		else if (ovl == OSS_OV_IDQ && flash_addr[15:0] == 16'h0002)
			val = {15'h0000, ~(persistent_protect_bit[sect] & dynamic_protect_bit[sect])};
		else if (ovl == OSS_OV_DYB)
			val = {15'h0000, dynamic_protect_bit[flash_addr[23:16]]};
	end

	// released bus shows the inverse of the last word, so stale data never matches
	assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? val : ~last;

	// end of a read: the one status read drops the status overlay
	always @(posedge flash_oe_n) begin
		last    <= val;
		st_pend <= 1'b0;
	end

	// commands commit on the rising write strobe, no extra latency
	always @(posedge flash_we_n) begin
		if (!flash_ce_n && flash_dq_oe) begin
			if (flash_dq_out == 16'h00f0) begin
				ovl   <= OSS_OV_READ;
				armed <= 1'b0;
			end else if (flash_dq_out == STAT_CMD)
				st_pend <= 1'b1;
			else if (ovl == OSS_OV_READ && flash_dq_out == 16'h0098
					&& flash_addr[15:0] == 16'h0055) begin
				ovl  <= OSS_OV_IDQ;
				sect <= flash_addr[23:16];
			end else if (ovl == OSS_OV_READ && flash_dq_out == ENT_DYB)
				ovl <= OSS_OV_DYB;
			else if (ovl == OSS_OV_DYB && armed) begin
				dynamic_protect_bit[flash_addr[23:16]] <= flash_dq_out[0];
				armed                  <= 1'b0;
			end else if (ovl == OSS_OV_DYB && flash_dq_out == PGM_CMD)
				armed <= 1'b1;
			// every other write leaves the overlay as it is
		end
	end
endmodule

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "oss_cfg.svh"

module tb_top
	import oss_pkg::*;
;
	typedef struct {
		logic [23:0] a;
		logic [15:0] d;
		logic [8:0]  c;
		logic [7:0]  ovl;
		logic        err;
		logic        rd;
		logic [15:0] rv;
	} oss_row_t;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, st, r;
	logic [23:0] flash_addr;
	logic [15:0] flash_dq_in, flash_dq_out;
	logic        flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, e;
	int          n_mismatch, comparisons;

	// ----------------------------------------------------------------
	// ordinary command table: inputs, then expected overlay, refusal, data
	// ----------------------------------------------------------------
	oss_row_t rows[24] = '{
		'{24'h010003, 16'h0000, 9'h000, 8'h01, 1'b0, 1'b1, 16'h5a59},
		'{24'h010000, 16'h0000, 9'h012, 8'h02, 1'b0, 1'b0, 16'h0000},
		'{24'h010002, 16'h0000, 9'h000, 8'h02, 1'b0, 1'b1, 16'h0001},
		'{24'h010002, 16'h0070, 9'h004, 8'h02, 1'b0, 1'b1, 16'h0080},
		'{24'h010002, 16'h0000, 9'h000, 8'h02, 1'b0, 1'b1, 16'h0001},
		'{24'h030002, 16'h0000, 9'h000, 8'h02, 1'b1, 1'b0, 16'h0000},
		'{24'h000000, 16'h0000, 9'h003, 8'h01, 1'b0, 1'b0, 16'h0000},
		'{24'h020000, 16'h0000, 9'h012, 8'h02, 1'b0, 1'b0, 16'h0000},
		'{24'h020002, 16'h0000, 9'h000, 8'h02, 1'b0, 1'b1, 16'h0000},
		'{24'h000000, 16'h0000, 9'h003, 8'h01, 1'b0, 1'b0, 16'h0000},
		'{24'h000000, 16'h0000, 9'h002, 8'h01, 1'b1, 1'b0, 16'h0000},
		'{24'h000000, 16'h00e0, 9'h072, 8'h80, 1'b0, 1'b0, 16'h0000},
		'{24'h010000, 16'h0000, 9'h012, 8'h80, 1'b1, 1'b0, 16'h0000},
		'{24'h030000, 16'h00a0, 9'h001, 8'h80, 1'b0, 1'b0, 16'h0000},
		'{24'h030000, 16'h0000, 9'h001, 8'h80, 1'b0, 1'b0, 16'h0000},
		'{24'h030004, 16'h0000, 9'h000, 8'h80, 1'b0, 1'b1, 16'h0000},
		'{24'h020004, 16'h0000, 9'h000, 8'h80, 1'b0, 1'b1, 16'h0001},
		'{24'h000000, 16'h0000, 9'h003, 8'h01, 1'b0, 1'b0, 16'h0000},
		'{24'h030000, 16'h0000, 9'h012, 8'h02, 1'b0, 1'b0, 16'h0000},
		'{24'h030002, 16'h0000, 9'h000, 8'h02, 1'b0, 1'b1, 16'h0001},
		'{24'h000000, 16'h0000, 9'h003, 8'h01, 1'b0, 1'b0, 16'h0000},
		'{24'h000007, 16'h0070, 9'h004, 8'h01, 1'b0, 1'b1, 16'h0080},
		'{24'h000007, 16'h0000, 9'h000, 8'h01, 1'b0, 1'b1, 16'h5a5d},
		'{24'h000000, 16'h0000, 9'h005, 8'h01, 1'b1, 1'b0, 16'h0000}
	};

	oss_ctrl #(.ADDR_W(24), .SECT_W(8), .DATA_W(16)) dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
		.flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n)
	);

	oss_flash_model flash (
		.flash_addr(flash_addr), .flash_dq_in(flash_dq_in),
		.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
		.flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n)
	);

	// 100 MHz clock
	always #5 pclk = ~pclk;

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	// one apb transfer; an edge passes first so strobes never toggle twice in a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			n_mismatch++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// poll status until the flash cycle is over, bounded
	task automatic wait_idle(output logic [31:0] s);
		logic x;
		int   n;
		n = 0;
		do begin
			apb(1'b0, `OSS_REG_STATUS, 32'h0, s, x);
			n++;
		end while (s[0] !== 1'b0 && n < 40);
		if (n >= 40)
			n_mismatch++;
	endtask

	task automatic cmd(input logic [23:0] a, input logic [15:0] d, input logic [8:0] c,
			output logic [31:0] s);
		logic x;
		apb(1'b1, `OSS_REG_ADDR, {8'h00, a}, s, x);
		apb(1'b1, `OSS_REG_WDATA, {16'h0000, d}, s, x);
		apb(1'b1, `OSS_REG_CTRL, {23'h000000, c}, s, x);
		wait_idle(s);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			cmd(rows[i].a, rows[i].d, rows[i].c, st);
			chk({24'h0, st[15:8]}, {24'h0, rows[i].ovl}, "overlay");
			chk({31'h0, st[1]}, {31'h0, rows[i].err}, "refusal");
			if (rows[i].err)
				apb(1'b1, `OSS_REG_STATUS, 32'h2, r, e);
			if (rows[i].rd) begin
				apb(1'b0, `OSS_REG_RDATA, 32'h0, r, e);
				chk(r, {16'h0000, rows[i].rv}, "read word");
			end
		end
		// unmapped offsets answer with an error and read as zero
		apb(1'b0, 8'h18, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h80000000, "unmapped read");
		apb(1'b1, 8'h1c, 32'hffffffff, r, e);
		chk({31'h0, e}, 32'h1, "unmapped write");
		// a command arriving while the flash is busy is dropped
		apb(1'b1, `OSS_REG_CTRL, 32'h0, r, e);
		apb(1'b1, `OSS_REG_CTRL, 32'h0, r, e);
		wait_idle(st);
		chk({31'h0, st[1]}, 32'h1, "busy refusal");
		apb(1'b1, `OSS_REG_STATUS, 32'h2, r, e);
		// reset inside an overlay: pins idle, overlay back to read
		cmd(24'h000000, 16'h00e0, 9'h072, st);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({27'h0, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, pready},
			32'h1c, "pins in reset");
		presetn <= 1'b1;
		apb(1'b0, `OSS_REG_STATUS, 32'h0, r, e);
		chk({16'h0000, r[15:0]}, 32'h0100, "status after reset");
		end_of_test();
	end

	// watchdog: the whole sequence needs about a thousand cycles
	initial begin
		#200000;
		n_mismatch++;
		end_of_test();
	end
endmodule

`default_nettype wire
